//--- rtl/burst_restart_ctrl.sv
// Burst mode and auto-restart protection control unit
`timescale 1ns/10ps
module burst_restart_ctrl
  import burst_restart_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES   = BLANK_CYC,
  parameter int unsigned SPIKE_CYCLES   = SPIKE_CYC,
  parameter int unsigned OVP_HI_CYCLES  = OVP_HI_CYC,
  parameter int unsigned UVLO_CYCLES    = UVLO_CYC,
  parameter int unsigned ENA_BLK_CYCLES = ENA_BLK_CYC,
  parameter int unsigned SOFT_CYCLES    = BLANK_CYC
) (
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      reset,
  // Comparator and thermal indications, asynchronous
  input  wire sense_type sense_raw,
  // Control outputs
  output ctrl_type       ctrl
);

  // ****************************************************************
  // Input synchronization and persistence filters
  // ****************************************************************

  sense_type sense;

  input_sync u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .raw     (sense_raw),
    .synced  (sense)
  );

  typedef struct packed {
    phase_type        phase;
    logic [CNT_W-1:0] burst_cnt;
    logic [CNT_W-1:0] ovl_cnt;
    logic [CNT_W-1:0] soft_cnt;
    logic [CNT_W-1:0] ena_cnt;
    logic             ena_armed;
    logic             burst;
    logic             bias;
    logic             clamp_rel;
    logic             fault_seen;
  } ctl_state_type;

  ctl_state_type state_r;
  ctl_state_type state_nxt;

  // Phases in which the gate may switch
  function automatic logic is_switching(input phase_type ph);
    return (ph == ST_SOFT) || (ph == ST_RUN);
  endfunction

  logic in_soft;
  logic in_run;
  logic ovp_soft_cond;
  logic ovp_hi_cond;
  logic ovl_cond;
  logic ena_cond;
  logic ovp_soft_hit;
  logic ovp_hi_hit;
  logic temp_hit;
  logic ovl_hit;
  logic uvlo_hit;
  logic ena_hit;
  logic fault;
  logic active;

  assign in_soft = (state_r.phase == ST_SOFT);
  assign in_run  = (state_r.phase == ST_RUN);
  assign active  = is_switching(state_r.phase);

  // Fast faults bypass the extendable path; overload uses it
  assign ovp_soft_cond = sense.vcc_above_ovp_soft &
                         sense.fb_above_overload & in_soft;
  assign ovp_hi_cond   = sense.vcc_above_ovp_hi & ~state_r.burst
                         & active;
  assign ovl_cond      = state_r.clamp_rel & sense.ba_above_end
                         & sense.fb_above_overload;
  assign ena_cond      = sense.ba_below_enable & state_r.ena_armed
                         & active;

  persist_filter #(.LIMIT(SPIKE_CYCLES)) u_ovp_soft (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cond    (ovp_soft_cond),
    .done    (ovp_soft_hit)
  );

  persist_filter #(.LIMIT(OVP_HI_CYCLES)) u_ovp_hi (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cond    (ovp_hi_cond),
    .done    (ovp_hi_hit)
  );

  persist_filter #(.LIMIT(SPIKE_CYCLES)) u_temp (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cond    (sense.over_temp & active),
    .done    (temp_hit)
  );

  persist_filter #(.LIMIT(SPIKE_CYCLES)) u_ovl (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cond    (ovl_cond),
    .done    (ovl_hit)
  );

  persist_filter #(.LIMIT(UVLO_CYCLES)) u_uvlo (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cond    (sense.vcc_below_off & active),
    .done    (uvlo_hit)
  );

  persist_filter #(.LIMIT(SPIKE_CYCLES)) u_ena (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cond    (ena_cond),
    .done    (ena_hit)
  );

  assign fault = ovp_soft_hit | ovp_hi_hit | temp_hit | ovl_hit
               | uvlo_hit | ena_hit;

  // ****************************************************************
  // Control state update
  // ****************************************************************

  always_comb begin
    state_nxt = state_r;
    case (state_r.phase)
      ST_OFF: begin
        state_nxt.bias = 1'b0;
        if (sense.vcc_above_on) begin
          state_nxt.phase    = ST_SOFT;
          state_nxt.soft_cnt = '0;
          state_nxt.bias     = 1'b1;
        end
      end
      ST_SOFT: begin
        if (state_r.soft_cnt >= CNT_W'(SOFT_CYCLES - 1)) begin
          state_nxt.phase = ST_RUN;
        end else begin
          state_nxt.soft_cnt = state_r.soft_cnt + CNT_W'(1);
        end
      end
      ST_RUN: begin
      end
      ST_RESTART: begin
        // Wait for supply to fall, then charge back up
        if (sense.vcc_above_on && state_r.fault_seen) begin
          state_nxt.phase      = ST_SOFT;
          state_nxt.soft_cnt   = '0;
          state_nxt.bias       = 1'b1;
          state_nxt.fault_seen = 1'b0;
        end else if (sense.vcc_below_off) begin
          state_nxt.fault_seen = 1'b1;
        end
      end
      default: begin
        state_nxt.phase = ST_OFF;
      end
    endcase

    // Auto-restart enable blanking after start of switching
    if (state_r.phase == ST_OFF || state_r.phase == ST_RESTART) begin
      state_nxt.ena_cnt   = '0;
      state_nxt.ena_armed = 1'b0;
    end else if (state_r.ena_cnt >= CNT_W'(ENA_BLK_CYCLES - 1)) begin
      state_nxt.ena_armed = 1'b1;
    end else begin
      state_nxt.ena_cnt = state_r.ena_cnt + CNT_W'(1);
    end

    // Burst entry blanking
    if (!in_run || state_r.burst || !sense.fb_below_entry) begin
      state_nxt.burst_cnt = '0;
    end else if (state_r.burst_cnt >= CNT_W'(BLANK_CYCLES - 1)) begin
      state_nxt.burst     = 1'b1;
      state_nxt.bias      = 1'b0;
      state_nxt.burst_cnt = '0;
    end else begin
      state_nxt.burst_cnt = state_r.burst_cnt + CNT_W'(1);
    end

    // Burst regulation and exit
    if (state_r.burst) begin
      if (sense.fb_above_overload) begin
        state_nxt.burst = 1'b0;
        state_nxt.bias  = 1'b1;
      end else if (sense.fb_above_wake) begin
        state_nxt.bias = 1'b1;
      end else if (sense.fb_below_sleep) begin
        state_nxt.bias = 1'b0;
      end
    end

    // Overload blanking and clamp release
    if (!active || !sense.fb_above_overload
        || state_r.burst) begin
      state_nxt.ovl_cnt   = '0;
      state_nxt.clamp_rel = 1'b0;
    end else if (state_r.ovl_cnt >= CNT_W'(BLANK_CYCLES - 1)) begin
      state_nxt.clamp_rel = 1'b1;
    end else begin
      state_nxt.ovl_cnt = state_r.ovl_cnt + CNT_W'(1);
    end

    // Any filtered fault forces auto-restart
    if (fault && active) begin
      state_nxt.phase      = ST_RESTART;
      state_nxt.burst      = 1'b0;
      state_nxt.bias       = 1'b0;
      state_nxt.clamp_rel  = 1'b0;
      state_nxt.fault_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= '{phase: ST_OFF, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  always_comb begin
    ctrl                 = '0;
    ctrl.burst_flag      = state_r.burst;
    ctrl.bias_enable     = state_r.bias;
    ctrl.reduced_limit   = state_r.burst;
    ctrl.clamp_release   = state_r.clamp_rel;
    ctrl.gate_stop       = ~state_r.bias | ~active
                           | ena_cond;
    ctrl.restart_active  = (state_r.phase == ST_RESTART);
    ctrl.startup_cell_on = (state_r.phase == ST_RESTART)
                           & state_r.fault_seen & ~state_r.burst;
    ctrl.soft_start      = in_soft;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  burst_limit_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    ctrl.burst_flag == ctrl.reduced_limit)
    else $error("reduced limit not tied to burst");

  burst_exit_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r.burst && sense.fb_above_overload && !fault
      |=> !ctrl.burst_flag && ctrl.bias_enable)
    else $error("burst not left on overload feedback");

  burst_wake_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r.burst && sense.fb_above_wake && !fault
      |=> ctrl.bias_enable)
    else $error("bias not woken in burst");

  burst_sleep_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    state_r.burst && !sense.fb_above_wake && !sense.fb_above_overload
      && sense.fb_below_sleep |=> !ctrl.bias_enable)
    else $error("bias not slept in burst");

  burst_entry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(state_r.burst) |-> $past(sense.fb_below_entry)
      && $past(state_r.burst_cnt) == CNT_W'(BLANK_CYCLES - 1))
    else $error("burst entered early");

  entry_hold_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    !sense.fb_below_entry |=> state_r.burst_cnt == '0)
    else $error("entry counter ran on high feedback");

  startup_off_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    ctrl.burst_flag |-> !ctrl.startup_cell_on)
    else $error("startup cell on in burst");

  clamp_time_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(state_r.clamp_rel) |->
      $past(state_r.ovl_cnt) == CNT_W'(BLANK_CYCLES - 1))
    else $error("clamp released at wrong time");

  restart_stop_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    ctrl.restart_active |-> ctrl.gate_stop && !ctrl.bias_enable)
    else $error("switching during restart");

  ena_blank_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(ctrl.restart_active) |-> ##1 !state_r.ena_armed [*8])
    else $error("enable input not blanked at start");

  burst_quiet_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(ctrl.burst_flag) |-> !ctrl.bias_enable && ctrl.gate_stop)
    else $error("bias left on at burst entry");

  ovp_masked_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    ctrl.burst_flag |=> !ovp_hi_hit)
    else $error("supply overvoltage counted in burst");

  soft_retry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(ctrl.restart_active) |-> ctrl.soft_start)
    else $error("restart left without soft start");

  fault_entry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    fault && active |=> ctrl.restart_active)
    else $error("filtered fault did not restart");

  enable_stop_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    sense.ba_below_enable && state_r.ena_armed && in_run |-> ctrl.gate_stop)
    else $error("gate not stopped by enable pull-down");

  clamp_drop_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    !sense.fb_above_overload |=> !ctrl.clamp_release)
    else $error("clamp held without overload feedback");

  cov_burst_c: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(state_r.burst));
  cov_restart_c: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(ctrl.restart_active));
  cov_clamp_c: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(ctrl.clamp_release));
  cov_retry_c: cover property (@(posedge sys_clk) disable iff (reset)
    ctrl.restart_active ##1 ctrl.soft_start);
  cov_enable_c: cover property (@(posedge sys_clk) disable iff (reset)
    ena_hit);

endmodule

//--- rtl/burst_restart_pkg.sv
// Constants and types for the burst and auto-restart control unit
// Functional notes
// - Burst entry counter runs only while feedback low
// - Enter burst at 20 ms if still low
// - Burst entry sets flag, bias off
// - Feedback above 3.5 V wakes bias
// - Burst selects reduced 0.34 V current limit
// - Feedback at 3.0 V switches bias off
// - Feedback over 4.0 V leaves burst
// - Only overload uses the extendable blanking path
// - Soft-start overvoltage with high feedback, 30 us
// - Supply over 25.5 V, 150 us, not burst
// - Thermal flag held 30 us restarts
// - Overload 20 ms releases blanking clamp switch
// - Expired blanking and pin high, 30 us
// - Undervoltage 10 ms plus filter restarts
// - Pin pull-down stops gate, ignored first 1 ms
// - Restart: stop, startup cell, then soft start
// - After startup recheck fault, retry or resume
// - Soft start on every restart attempt
// - Startup cell stays off during burst
package burst_restart_pkg;

  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned BLANK_MS     = 20;
  localparam int unsigned SPIKE_US     = 30;
  localparam int unsigned OVP_HI_US    = 120;
  localparam int unsigned UVLO_MS      = 10;
  localparam int unsigned ENA_BLANK_MS = 1;

  localparam int unsigned BLANK_CYC   = CLK_HZ / 1000 * BLANK_MS;
  localparam int unsigned SPIKE_CYC   = CLK_HZ / 1_000_000 * SPIKE_US;
  localparam int unsigned OVP_HI_CYC  =
    CLK_HZ / 1_000_000 * (OVP_HI_US + SPIKE_US);
  localparam int unsigned UVLO_CYC    =
    CLK_HZ / 1000 * UVLO_MS + SPIKE_CYC;
  localparam int unsigned ENA_BLK_CYC = CLK_HZ / 1000 * ENA_BLANK_MS;

  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_SOFT    = 2'b01,
    ST_RUN     = 2'b11,
    ST_RESTART = 2'b10
  } phase_type;

  typedef struct packed {
    logic fb_below_entry;
    logic fb_above_wake;
    logic fb_below_sleep;
    logic fb_above_overload;
    logic vcc_above_on;
    logic vcc_below_off;
    logic vcc_above_ovp_soft;
    logic vcc_above_ovp_hi;
    logic ba_above_end;
    logic ba_below_enable;
    logic over_temp;
  } sense_type;

  typedef struct packed {
    logic burst_flag;
    logic bias_enable;
    logic reduced_limit;
    logic clamp_release;
    logic gate_stop;
    logic restart_active;
    logic startup_cell_on;
    logic soft_start;
  } ctrl_type;

endpackage

//--- rtl/persist_filter.sv
// Counts how long a condition stays true
`timescale 1ns/10ps
module persist_filter
  import burst_restart_pkg::*;
#(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Condition and result
  input  wire logic cond,
  output logic      done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } pf_state_type;

  pf_state_type state_r;
  pf_state_type state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (!cond) begin
      state_nxt.cnt  = '0;
      state_nxt.done = 1'b0;
    end else if (state_r.cnt >= CNT_W'(LIMIT - 1)) begin
      state_nxt.done = 1'b1;
    end else begin
      state_nxt.cnt = state_r.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign done = state_r.done;

endmodule

//--- rtl/input_sync.sv
// Two-stage synchronizer for the comparator and thermal inputs
`timescale 1ns/10ps
module input_sync
  import burst_restart_pkg::*;
(
  // Clock and reset
  input  wire logic      sys_clk,
  input  wire logic      reset,
  // Raw and synchronized sense bits
  input  wire sense_type raw,
  output sense_type      synced
);

  typedef struct packed {
    sense_type s1;
    sense_type s2;
  } sync_state_type;

  sync_state_type state_r;
  sync_state_type state_nxt;

  always_comb begin
    state_nxt    = state_r;
    state_nxt.s1 = raw;
    state_nxt.s2 = state_r.s1;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign synced = state_r.s2;

endmodule

//--- sim/analog_stage.sv
// Comparator and blanking pin model facing the control unit
`timescale 1ns/10ps
module analog_stage
  import burst_restart_pkg::*;
#(
  parameter int unsigned CHARGE = 12
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Pin levels from the bench, millivolts
  input  wire logic [15:0] fb_mv,
  input  wire logic [15:0] vcc_mv,
  input  wire logic        ba_pull_low,
  input  wire logic        hot,
  // Clamp switch from the control unit
  input  wire logic        clamp_release,
  // Comparator results
  output sense_type        sense
);
  int          chg_r;
  logic [15:0] ba_mv;

  // ************************************************
  // Extension capacitor charge from clamp to 4.1 V
  // ************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chg_r <= 0;
    end else if (!clamp_release) begin
      chg_r <= 0;
    end else if (chg_r < CHARGE) begin
      chg_r <= chg_r + 1;
    end
  end
  assign ba_mv = ba_pull_low ? 16'h0064 :
                 (clamp_release && chg_r == CHARGE) ? 16'h1004 : 16'h0384;

  // ************************************************
  // Threshold comparators
  // ************************************************
  always_comb begin
    sense.fb_below_entry     = fb_mv < 16'd1350;
    sense.fb_above_wake      = fb_mv > 16'd3500;
    sense.fb_below_sleep     = fb_mv <= 16'd3000;
    sense.fb_above_overload  = fb_mv > 16'd4000;
    sense.vcc_above_on       = vcc_mv >= 16'd18000;
    sense.vcc_below_off      = vcc_mv < 16'd10500;
    sense.vcc_above_ovp_soft = vcc_mv > 16'd20500;
    sense.vcc_above_ovp_hi   = vcc_mv > 16'd25500;
    sense.ba_above_end       = ba_mv > 16'd4000;
    sense.ba_below_enable    = ba_mv < 16'd330;
    sense.over_temp          = hot;
  end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the burst and auto-restart control unit
`timescale 1ns/10ps
module tb_top;
  import burst_restart_pkg::*;
  localparam int BLK = 50, SPK = 5, OVH = 10, UVL = 40, ENA = 20;
  localparam int SFT = 100, CHG = 12;
  localparam int I_BIAS = 6, I_RED = 5, I_CLAMP = 4, I_BURST = 7;
  localparam int I_GATE = 3, I_RST = 2, I_CELL = 1, I_SOFT = 0;
  logic        sys_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic [15:0] fb_mv       = 16'd2000;
  logic [15:0] vcc_mv      = 16'd5000;
  logic        ba_pull_low = 1'b0;
  logic        hot         = 1'b0;
  sense_type   sense_raw;
  ctrl_type    ctrl;
  int          mismatches  = 0;
  int          cmp_count   = 0;
  string bn [8] = '{"soft_start", "startup_cell_on", "restart_active",
    "gate_stop", "clamp_release", "reduced_limit", "bias_enable",
    "burst_flag"};

  always #10 sys_clk = ~sys_clk;

  analog_stage #(.CHARGE(CHG)) stage (
    .sys_clk(sys_clk), .reset(reset), .fb_mv(fb_mv), .vcc_mv(vcc_mv),
    .ba_pull_low(ba_pull_low), .hot(hot),
    .clamp_release(ctrl.clamp_release), .sense(sense_raw));

  burst_restart_ctrl #(.BLANK_CYCLES(BLK), .SPIKE_CYCLES(SPK),
    .OVP_HI_CYCLES(OVH), .UVLO_CYCLES(UVL), .ENA_BLK_CYCLES(ENA),
    .SOFT_CYCLES(SFT)) dut (
    .sys_clk(sys_clk), .reset(reset), .sense_raw(sense_raw), .ctrl(ctrl));

  // ************************************************
  // Checking tasks
  // ************************************************
  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic chk(int i, logic e);
    cmp_count++;
    if (ctrl[i] !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", bn[i], e, ctrl[i]);
    end
  endtask

  // Output must keep its value every cycle
  task automatic hold(int i, logic v, int n);
    repeat (n) begin
      step(1);
      chk(i, v);
    end
  endtask

  // Bounded wait; running out ends the run
  task automatic await(int i, logic v, int lim);
    int k;
    for (k = 0; k < lim && ctrl[i] !== v; k++) begin
      step(1);
    end
    chk(i, v);
    if (ctrl[i] !== v) begin
      final_report();
    end
  endtask

  task automatic to_soft(logic pull);
    vcc_mv = 16'd10000;
    await(I_CELL, 1'b1, 8);
    chk(I_SOFT, 1'b0);
    vcc_mv = 16'd18500;
    ba_pull_low = pull;
    await(I_CELL, 1'b0, 8);
    await(I_SOFT, 1'b1, 6);
  endtask

  task automatic to_run(logic pull);
    to_soft(pull);
    if (pull) begin
      hold(I_RST, 1'b0, ENA - 8);
      ba_pull_low = 1'b0;
    end
    await(I_SOFT, 1'b0, SFT + 8);
    chk(I_RST, 1'b0);
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    void'($urandom(27702));
    repeat (3) @(posedge sys_clk);
    #1 reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      chk(i, i == I_GATE);
    end
    vcc_mv = 16'd18500;
    await(I_SOFT, 1'b1, 6);
    await(I_SOFT, 1'b0, SFT + 8);
    repeat (3) begin
      fb_mv = 16'd1000;
      step(5 + $urandom % (BLK - 15));
      fb_mv = 16'(1400 + $urandom % 2000);
      hold(I_BURST, 1'b0, BLK + 6);
    end
    fb_mv = 16'd1000;
    hold(I_BURST, 1'b0, BLK - 4);
    await(I_BURST, 1'b1, 10);
    chk(I_RED, 1'b1);
    chk(I_BIAS, 1'b0);
    chk(I_GATE, 1'b1);
    fb_mv = 16'd3700;
    await(I_BIAS, 1'b1, 6);
    chk(I_BURST, 1'b1);
    chk(I_GATE, 1'b0);
    fb_mv = 16'd2900;
    await(I_BIAS, 1'b0, 6);
    vcc_mv = 16'd26000;
    hold(I_RST, 1'b0, OVH + 15);
    chk(I_CELL, 1'b0);
    vcc_mv = 16'd18500;
    fb_mv = 16'd4200;
    await(I_BURST, 1'b0, 6);
    chk(I_RED, 1'b0);
    chk(I_BIAS, 1'b1);
    hold(I_CLAMP, 1'b0, BLK - 6);
    await(I_CLAMP, 1'b1, 14);
    hold(I_RST, 1'b0, CHG);
    await(I_RST, 1'b1, CHG + SPK + 10);
    fb_mv = 16'd2000;
    to_run(1'b1);
    ba_pull_low = 1'b1;
    await(I_GATE, 1'b1, 4);
    await(I_RST, 1'b1, SPK + 8);
    ba_pull_low = 1'b0;
    to_run(1'b0);
    hot = 1'b1;
    step(SPK - 2);
    hot = 1'b0;
    hold(I_RST, 1'b0, 10);
    hot = 1'b1;
    await(I_RST, 1'b1, SPK + 10);
    hot = 1'b0;
    to_run(1'b0);
    vcc_mv = 16'd26000;
    hold(I_RST, 1'b0, OVH - 4);
    await(I_RST, 1'b1, 12);
    to_run(1'b0);
    vcc_mv = 16'd10000;
    hold(I_RST, 1'b0, UVL - 4);
    await(I_RST, 1'b1, 12);
    to_soft(1'b0);
    vcc_mv = 16'd21000;
    fb_mv = 16'd4200;
    hold(I_RST, 1'b0, SPK);
    await(I_RST, 1'b1, SPK + 8);
    vcc_mv = 16'd18500;
    fb_mv = 16'd2000;
    to_run(1'b0);
    final_report();
  end
endmodule
